// [core/fsr_host.sv]
`default_nettype none
module fsr_host
   import fsr_pkg::*;
(
   input  wire logic        clk_sys,          // 50 MHz clock
   input  wire logic        arst_n,           // async reset, active low
   input  wire logic        psel,             // apb select
   input  wire logic        penable,          // apb access phase
   input  wire logic        pwrite,           // apb direction
   input  wire logic [7:0]  paddr,            // apb byte address
   input  wire logic [31:0] pwdata,           // apb write data
   output logic [31:0]      prdata,           // apb read data
   output logic             pready,           // apb ready
   output logic             pslverr,          // apb error, unmapped address
   output logic             irq,              // level interrupt
   input  wire logic        supply_ok,        // system supply good
   input  wire logic        status_pin,       // open-drain busy line, pulled up
   output logic [23:0]      flash_addr,       // flash address
   output logic [3:0]       flash_ce_n,       // chip enables, one per device
   output logic             flash_oe_n,       // shared output enable
   output logic             flash_we_n,       // write enable
   output logic             reset_powerdown_n,// reset/power-down drive
   input  wire logic [7:0]  flash_dq_i,       // data pins in
   output logic [7:0]       flash_dq_o,       // data pins out
   output logic             flash_dq_oe       // data pins driven
);
   import fsr_pkg::*;

   typedef enum logic [2:0] {
      FSR_ST_IDLE = 3'b000,
      FSR_ST_CMD  = 3'b001,
      FSR_ST_READ = 3'b010,
      FSR_ST_RST  = 3'b011,
      FSR_ST_FIN  = 3'b100
   } fsr_state_t;

   fsr_cyc_if  cyc ();

   fsr_state_t  st_q, st_d;
   fsr_op_t     op_q;
   logic [25:0] addr_q;
   logic [7:0]  data_q;
   logic [7:0]  dstat_q;
   logic [7:0]  xstat_q;
   logic [2:0]  istat_q;
   logic [2:0]  imask_q;
   logic [5:0]  rp_cnt_q;
   logic        rp_q;
   logic        sts_q;

   // apb decode: zero-wait slave, error on unmapped offset
   wire         wr_acc   = psel && penable && pwrite;
   wire         rd_acc   = psel && penable && !pwrite;
   wire         hit_ctrl = (paddr == FSR_OFF_CTRL);
   wire         hit_addr = (paddr == FSR_OFF_ADDR);
   wire         hit_data = (paddr == FSR_OFF_DATA);
   wire         hit_ist  = (paddr == FSR_OFF_ISTAT);
   wire         hit_imk  = (paddr == FSR_OFF_IMASK);
   wire         mapped   = hit_ctrl || hit_addr || hit_data || hit_ist || hit_imk ||
                           (paddr == FSR_OFF_DSTAT) || (paddr == FSR_OFF_XSTAT);
   wire         busy     = (st_q != FSR_ST_IDLE);
   wire         go       = wr_acc && hit_ctrl && pwdata[FSR_CTRL_GO_BIT] && !busy;
   wire fsr_op_t go_op   = fsr_op_t'(pwdata[FSR_CTRL_OP_LSB +: 3]);

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // read mux
   always_comb begin
      prdata = 32'h0;
      unique case (paddr)
         FSR_OFF_CTRL:  prdata = {22'h0, rp_q, busy, 1'b0, op_q, 4'h0};
         FSR_OFF_ADDR:  prdata = {6'h0, addr_q};
         FSR_OFF_DATA:  prdata = {24'h0, data_q};
         FSR_OFF_DSTAT: prdata = {24'h0, dstat_q};
         FSR_OFF_XSTAT: prdata = {24'h0, xstat_q};
         FSR_OFF_ISTAT: prdata = {29'h0, istat_q};
         FSR_OFF_IMASK: prdata = {29'h0, imask_q};
         default:       prdata = 32'h0;
      endcase
   end

   // results of a finished pin cycle; reserved bits are stripped before status decisions and snapshots, data_q takes the raw byte [RULE_04]
   wire         rd_done   = (st_q == FSR_ST_READ) && cyc.ack;
   wire  [7:0]  sr_view   = cyc.rdata & FSR_SR_DEFINED;          // [RULE_04]
   wire  [7:0]  xsr_view  = cyc.rdata & FSR_XSR_DEFINED;         // [RULE_04] [RULE_03]
   // error flags only count once the engine reports ready [RULE_12]
   wire         sr_ready  = sr_view[FSR_SR_READY_BIT];
   wire         xsr_free  = xsr_view[FSR_XSR_FREE_BIT];          // [RULE_01]
   wire         poll_more = rd_done && ((op_q == FSR_OP_POLL_SR && !sr_ready) ||
                                        (op_q == FSR_OP_POLL_XSR && !xsr_free));

   // command byte a sequence writes first
   assign cyc.req   = (st_q == FSR_ST_CMD) || (st_q == FSR_ST_READ);
   assign cyc.wr    = (st_q == FSR_ST_CMD);
   assign cyc.addr  = addr_q;
   assign cyc.wdata = (op_q == FSR_OP_POLL_SR)  ? FSR_CMD_READ_STATUS :
                      (op_q == FSR_OP_POLL_XSR) ? FSR_CMD_BUF_WRITE :
                      (op_q == FSR_OP_READ_ID)  ? FSR_CMD_READ_ID : data_q;

   // sequencer
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         FSR_ST_IDLE: begin
            if (go) begin
               unique case (go_op)
                  FSR_OP_READ:  st_d = FSR_ST_READ;
                  FSR_OP_RESET: st_d = FSR_ST_RST;
                  default:      st_d = FSR_ST_CMD;
               endcase
            end
         end
         FSR_ST_CMD:  if (cyc.ack) st_d = (op_q == FSR_OP_WRITE) ? FSR_ST_FIN : FSR_ST_READ;
         FSR_ST_READ: begin
            // buffer request is repeated until a buffer is free [RULE_02]
            if (cyc.ack) st_d = !poll_more ? FSR_ST_FIN :
                                (op_q == FSR_OP_POLL_XSR) ? FSR_ST_CMD : FSR_ST_READ;
         end
         FSR_ST_RST:  if (rp_cnt_q == 6'h0) st_d = FSR_ST_FIN;
         FSR_ST_FIN:  st_d = FSR_ST_IDLE;
         default:     st_d = FSR_ST_IDLE;
      endcase
   end

   // events: op finished, busy line released, error flag seen on a ready status
   wire         sts_rise = status_pin && !sts_q;                 // [RULE_10]
   wire         err_seen = rd_done && op_q == FSR_OP_POLL_SR && sr_ready && |(sr_view & FSR_SR_ERRORS);
   wire  [2:0]  ev_set   = {err_seen, sts_rise, st_q == FSR_ST_FIN};
   wire  [2:0]  ev_clr   = (wr_acc && hit_ist) ? pwdata[2:0] : 3'h0;
   assign irq = |(istat_q & imask_q);

   // control and register state
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q    <= FSR_ST_IDLE;
         op_q    <= FSR_OP_WRITE;
         addr_q  <= 26'h0;
         data_q  <= 8'h0;
         imask_q <= FSR_IRQ_RESET;
         sts_q   <= 1'b1;
      end else begin
         st_q  <= st_d;
         sts_q <= status_pin;
         if (go) op_q <= go_op;
         if (wr_acc && hit_addr && !busy) addr_q <= pwdata[25:0];
         if (wr_acc && hit_data && !busy) data_q <= pwdata[7:0];
         else if (rd_done) data_q <= cyc.rdata;   // lock codes land here for software [RULE_06]
         if (wr_acc && hit_imk) imask_q <= pwdata[2:0];
      end
   end

   // status snapshots, masked; erase-suspend flag kept for software [RULE_05]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dstat_q <= 8'h0;
         xstat_q <= 8'h0;
         istat_q <= FSR_IRQ_RESET;
      end else begin
         if (rd_done && op_q == FSR_OP_POLL_SR) dstat_q <= sr_view;     // [RULE_04]
         if (rd_done && op_q == FSR_OP_POLL_XSR) xstat_q <= xsr_view;   // [RULE_04]
         istat_q <= (istat_q & ~ev_clr) | ev_set;                       // set wins over clear
      end
   end

   // reset/power-down follows supply and is pulsed on request [RULE_09]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rp_cnt_q <= 6'h0;
         rp_q     <= 1'b0;
      end else begin
         if (go && go_op == FSR_OP_RESET) rp_cnt_q <= 6'(FSR_RP_CYC - 1);
         else if (rp_cnt_q != 6'h0) rp_cnt_q <= rp_cnt_q - 6'h1;
         rp_q <= supply_ok && (st_q != FSR_ST_RST) && !(go && go_op == FSR_OP_RESET);   // [RULE_09]
      end
   end
   assign reset_powerdown_n = rp_q;

   fsr_pin_cycle u_pins (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .cyc     (cyc.engine),
      .addr_o  (flash_addr),
      .ce_n    (flash_ce_n),
      .oe_n    (flash_oe_n),
      .we_n    (flash_we_n),
      .dq_i    (flash_dq_i),
      .dq_o    (flash_dq_o),
      .dq_oe   (flash_dq_oe)
   );

   property p_xsr_done_free;
      @(posedge clk_sys) disable iff (!arst_n)
      (st_q == FSR_ST_FIN && op_q == FSR_OP_POLL_XSR) |-> xstat_q[FSR_XSR_FREE_BIT];
   endproperty
   a_xsr_done_free: assert property (p_xsr_done_free)   // [RULE_02]
      else $error("buffer poll finished without a free buffer");

   property p_reserved_masked;
      @(posedge clk_sys) disable iff (!arst_n)
      ((dstat_q & ~FSR_SR_DEFINED) == 8'h0) && ((xstat_q & ~FSR_XSR_DEFINED) == 8'h0);
   endproperty
   a_reserved_masked: assert property (p_reserved_masked)   // [RULE_04]
      else $error("reserved status bit kept");

   property p_id_cmd_first;
      @(posedge clk_sys) disable iff (!arst_n)
      (st_q == FSR_ST_CMD && cyc.ack && op_q == FSR_OP_READ_ID) |->
         cyc.wdata == FSR_CMD_READ_ID ##1 st_q == FSR_ST_READ;
   endproperty
   a_id_cmd_first: assert property (p_id_cmd_first)   // [RULE_06]
      else $error("identifier read not preceded by its command");

   property p_rp_follows_supply;
      @(posedge clk_sys) disable iff (!arst_n)
      !supply_ok |=> !reset_powerdown_n;
   endproperty
   a_rp_follows_supply: assert property (p_rp_follows_supply)   // [RULE_09]
      else $error("reset/power-down high without supply");

   property p_rp_pulse;
      @(posedge clk_sys) disable iff (!arst_n)
      (go && go_op == FSR_OP_RESET) |=> !reset_powerdown_n [*8];
   endproperty
   a_rp_pulse: assert property (p_rp_pulse)   // [RULE_09]
      else $error("reset pulse too short");
endmodule : fsr_host
`default_nettype wire

// [core/fsr_pkg.sv]
// Notes on behaviour
// (RULE_01) The extended status top bit reads 1 while a write buffer is free and 0 while none is.
// (RULE_02) After a buffered-write command the host polls extended status and loads data only once its top bit is 1.
// (RULE_03) The seven low bits of extended status are reserved and carry no status.
// (RULE_04) The host masks every reserved status bit and decides only on the defined flags.
// (RULE_05) The erase-suspend flag is 1 while an erase is suspended and 0 while it runs or has finished.
// (RULE_06) The host learns lock state by reading the lock configuration codes with the identifier-read command.
// (RULE_07) A deselected device keeps its data outputs off and stays in standby.
// (RULE_08) One shared output enable comes from the host read strobe and a decoder drives each device's chip enable.
// (RULE_09) The reset/power-down input follows the supply-good signal and is toggled during system reset.
// (RULE_10) In default mode the status pin goes low after a write-engine command and floats once the engine is done.
// (RULE_11) The command decoder enters read-array mode at power-up, after reset/power-down and after a supply dip.
// (RULE_12) The status top bit reads 1 when the engine is ready; other error flags are valid only then.
`default_nettype none
package fsr_pkg;
   // apb register offsets
   localparam logic [7:0] FSR_OFF_CTRL  = 8'h00;
   localparam logic [7:0] FSR_OFF_ADDR  = 8'h04;
   localparam logic [7:0] FSR_OFF_DATA  = 8'h08;
   localparam logic [7:0] FSR_OFF_DSTAT = 8'h0c;
   localparam logic [7:0] FSR_OFF_XSTAT = 8'h10;
   localparam logic [7:0] FSR_OFF_ISTAT = 8'h14;
   localparam logic [7:0] FSR_OFF_IMASK = 8'h18;
   // control fields
   localparam int FSR_CTRL_GO_BIT   = 0;
   localparam int FSR_CTRL_OP_LSB   = 4;
   localparam int FSR_CTRL_BUSY_BIT = 8;
   localparam int FSR_CTRL_RP_BIT   = 9;
   localparam int FSR_ADDR_SEL_LSB  = 24;
   // interrupt status bits
   localparam int FSR_EV_DONE = 0;
   localparam int FSR_EV_STS  = 1;
   localparam int FSR_EV_ERR  = 2;
   localparam logic [2:0] FSR_IRQ_RESET = 3'h0;
   // device status field positions and masks of the defined flags
   localparam int FSR_SR_READY_BIT  = 7;
   localparam int FSR_SR_SUSP_BIT   = 6;
   localparam int FSR_XSR_FREE_BIT  = 7;
   localparam logic [7:0] FSR_SR_DEFINED  = 8'hfa;
   localparam logic [7:0] FSR_SR_ERRORS   = 8'h3a;
   localparam logic [7:0] FSR_XSR_DEFINED = 8'h80;
   // device commands
   localparam logic [7:0] FSR_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FSR_CMD_BUF_WRITE   = 8'he8;
   localparam logic [7:0] FSR_CMD_READ_ID     = 8'h90;
   // timing
   localparam int FSR_CLK_NS    = 20;
   localparam int FSR_T_ACC_NS  = 150;
   localparam int FSR_T_WP_NS   = 70;
   localparam int FSR_T_RP_NS   = 1000;
   localparam int FSR_ACC_CYC   = (FSR_T_ACC_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
   localparam int FSR_WP_CYC    = (FSR_T_WP_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
   localparam int FSR_RP_CYC    = (FSR_T_RP_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
   // operations the controller runs
   typedef enum logic [2:0] {
      FSR_OP_WRITE    = 3'b000,
      FSR_OP_READ     = 3'b001,
      FSR_OP_POLL_SR  = 3'b010,
      FSR_OP_POLL_XSR = 3'b011,
      FSR_OP_READ_ID  = 3'b100,
      FSR_OP_RESET    = 3'b101
   } fsr_op_t;
endpackage : fsr_pkg
`default_nettype wire

// [core/fsr_cyc_if.sv]
`default_nettype none
// one flash bus cycle request between sequencer and pin engine
interface fsr_cyc_if;
   logic        req;
   logic        wr;
   logic [25:0] addr;
   logic [7:0]  wdata;
   logic        ack;
   logic [7:0]  rdata;
   modport master (output req, wr, addr, wdata, input ack, rdata);
   modport engine (input req, wr, addr, wdata, output ack, rdata);
endinterface : fsr_cyc_if
`default_nettype wire

// [core/fsr_pin_cycle.sv]
`default_nettype none
module fsr_pin_cycle
   import fsr_pkg::*;
(
   input  wire logic    clk_sys,   // system clock
   input  wire logic    arst_n,    // async reset
   fsr_cyc_if.engine    cyc,       // cycle request
   output logic [23:0]  addr_o,    // flash address
   output logic [3:0]   ce_n,      // per-device chip enables
   output logic         oe_n,      // shared output enable
   output logic         we_n,      // write enable
   input  wire logic [7:0] dq_i,   // data pins in
   output logic [7:0]   dq_o,      // data pins out
   output logic         dq_oe      // data pins driven
);
   import fsr_pkg::*;

   typedef enum logic [1:0] {
      FSR_PC_IDLE  = 2'b00,
      FSR_PC_SETUP = 2'b01,
      FSR_PC_STRB  = 2'b10,
      FSR_PC_HOLD  = 2'b11
   } fsr_pc_t;

   fsr_pc_t     st_q, st_d;
   logic [3:0]  cnt_q;
   logic        wr_q;
   logic [1:0]  sel_q;
   logic [7:0]  rdata_q;
   wire         strobe_end = (st_q == FSR_PC_STRB) && (cnt_q == 4'h0);
   wire  [3:0]  strobe_len = wr_q ? 4'(FSR_WP_CYC - 1) : 4'(FSR_ACC_CYC - 1);
   wire         sel_on     = (st_q != FSR_PC_IDLE) && (st_q != FSR_PC_HOLD);

   // next state of one bus cycle
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         FSR_PC_IDLE:  if (cyc.req) st_d = FSR_PC_SETUP;
         FSR_PC_SETUP: st_d = FSR_PC_STRB;
         FSR_PC_STRB:  if (strobe_end) st_d = FSR_PC_HOLD;
         FSR_PC_HOLD:  st_d = FSR_PC_IDLE;
      endcase
   end

   // decoder drives one chip enable, all others stay high so idle parts rest [RULE_08]
   assign ce_n      = sel_on ? ~(4'h1 << sel_q) : 4'hf;
   assign oe_n      = !((st_q == FSR_PC_STRB) && !wr_q);   // shared read strobe [RULE_08]
   assign we_n      = !((st_q == FSR_PC_STRB) && wr_q);
   assign dq_oe     = sel_on && wr_q;
   assign cyc.ack   = (st_q == FSR_PC_HOLD);
   assign cyc.rdata = rdata_q;

   // latch request; hold recovery cycle so a lingering req is never taken twice
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q    <= FSR_PC_IDLE;
         cnt_q   <= 4'h0;
         wr_q    <= 1'b0;
         sel_q   <= 2'h0;
         addr_o  <= 24'h0;
         dq_o    <= 8'h0;
         rdata_q <= 8'h0;
      end else begin
         st_q <= st_d;
         if (st_q == FSR_PC_IDLE && cyc.req) begin
            wr_q   <= cyc.wr;
            sel_q  <= cyc.addr[25:24];
            addr_o <= cyc.addr[23:0];
            dq_o   <= cyc.wdata;
         end
         if (st_q == FSR_PC_SETUP) cnt_q <= strobe_len;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
         if (strobe_end && !wr_q) rdata_q <= dq_i;   // sample at end of access time
      end
   end

   property p_oe_only_selected_read;
      @(posedge clk_sys) disable iff (!arst_n)
      !oe_n |-> (ce_n != 4'hf) && we_n && !dq_oe;
   endproperty
   a_oe_only_selected_read: assert property (p_oe_only_selected_read)   // [RULE_08]
      else $error("output enable without a selected read");
endmodule : fsr_pin_cycle
`default_nettype wire

// [test/fsr_flash_model.sv]
`default_nettype none
// behavioural flash device on chip enable 0: array, status, extended status and id reads
module fsr_flash_model #(
   parameter logic [7:0] ID_CODE = 8'h5a   // arbitrary identifier value
) (
   input  wire logic        ce_n,          // chip enable
   input  wire logic        oe_n,          // output enable
   input  wire logic        we_n,          // write enable
   input  wire logic        rp_n,          // reset/power-down
   input  wire logic [23:0] addr,          // address
   input  wire logic [7:0]  dq_in,         // data from host
   output logic      [7:0]  dq_out,        // data to host, garbage when released
   output logic             status_pin,    // busy line after its pull-up
   input  wire logic        arm,           // high loads the busy counts
   input  wire logic [7:0]  busy_reads,    // status reads before ready
   input  wire logic [7:0]  xbusy_reads,   // xstatus reads before a buffer frees
   input  wire logic [7:0]  sr_flags       // flags shown once ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] mode_q;   // 0 array, 1 status, 2 xstatus, 3 id
   logic [7:0] sr_cnt;
   logic [7:0] xsr_cnt;
   logic [7:0] last;
   logic [7:0] val;
   logic       drive;
   logic       rd_sel;
   // command decoder, back to array on reset/power-down
   // taken as the write strobe falls: chip enable and data leave together with its rise
   always @(negedge we_n or negedge rp_n) begin
      if (!rp_n) mode_q = 2'd0;
      else if (!ce_n) mode_q = (dq_in == 8'h70) ? 2'd1 :
                               (dq_in == 8'he8) ? 2'd2 :
                               (dq_in == 8'h90) ? 2'd3 : 2'd0;
   end
   // selection noted as the read strobe falls, since chip enable lifts with its rise
   always @(negedge oe_n) rd_sel = !ce_n;
   // engine and buffer stay busy for a set number of reads
   always @(posedge oe_n or posedge arm or negedge rp_n) begin
      if (!rp_n) begin
         sr_cnt = 8'h00;
         xsr_cnt = 8'h00;
      end else if (arm) begin
         sr_cnt = busy_reads;
         xsr_cnt = xbusy_reads;
      end else if (rd_sel && mode_q == 2'd1 && sr_cnt != 8'h00) sr_cnt = sr_cnt - 8'h01;
      else if (rd_sel && mode_q == 2'd2 && xsr_cnt != 8'h00) xsr_cnt = xsr_cnt - 8'h01;
   end
   // reserved status bits read as ones, extended status low bits as 5b, so an unmasked host shows it
   always_comb begin
      case (mode_q)
         2'd0: val = addr[7:0] ^ 8'h3c;
         2'd1: val = (sr_cnt != 8'h00) ? 8'h55 : ({1'b1, sr_flags[6:0]} | 8'h05);
         2'd2: val = {xsr_cnt == 8'h00, 7'h5b};
         default: val = ID_CODE;
      endcase
   end
   // outputs only while selected and read, else the inverse of the last byte
   assign drive = rp_n && !ce_n && !oe_n;
   always @(val or drive) begin
      if (drive) last = val;
   end
   assign dq_out = drive ? val : ~last;
   // pulled high when idle or in power-down
   assign status_pin = !(rp_n && sr_cnt != 8'h00);
endmodule // fsr_flash_model
`default_nettype wire

// [test/flash_status_reporting_test.sv]
`default_nettype none
module flash_status_reporting_test;
   timeunit 1ns;
   timeprecision 1ps;
   import fsr_pkg::*;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        supply_ok = 1'b1;
   logic        arm = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [7:0]  busy_reads = 8'h00;
   logic [7:0]  xbusy_reads = 8'h00;
   logic [7:0]  sr_flags = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, status_pin, rp_n, oe_n, we_n, dq_oe, err;
   logic [23:0] faddr;
   logic [3:0]  ce_n;
   logic [7:0]  dq_o, dq_i, dev_dq;
   int          n_fail = 0;
   int          checks = 0;
   int          cyc = 0;

   always #10 clk_sys = ~clk_sys;
   assign dq_i = dq_oe ? dq_o : dev_dq;

   fsr_host dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .supply_ok(supply_ok), .status_pin(status_pin), .flash_addr(faddr), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rp_n), .flash_dq_i(dq_i),
      .flash_dq_o(dq_o), .flash_dq_oe(dq_oe));
   fsr_flash_model u_dev (.ce_n(ce_n[0]), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .addr(faddr), .dq_in(dq_i),
      .dq_out(dev_dq), .status_pin(status_pin), .arm(arm), .busy_reads(busy_reads),
      .xbusy_reads(xbusy_reads), .sr_flags(sr_flags));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 2000; i++) begin
         apb(1'b0, FSR_OFF_CTRL, 32'h0);
         if (rd[FSR_CTRL_BUSY_BIT] === 1'b0) break;
      end
      chk("ctrl idle", 32'h0, {31'h0, rd[FSR_CTRL_BUSY_BIT]});
   endtask
   task automatic run_op(input logic [2:0] op);
      apb(1'b1, FSR_OFF_CTRL, {25'h0, op, 4'h1});
      wait_idle();
   endtask
   // busy counts and ready flags the device will show
   task automatic arm_dev(input logic [7:0] b, input logic [7:0] x, input logic [7:0] f);
      @(posedge clk_sys);
      busy_reads <= b;
      xbusy_reads <= x;
      sr_flags <= f;
      arm <= 1'b1;
      @(posedge clk_sys);
      arm <= 1'b0;
   endtask

   // hang guard and bus watch: one device selected, no contention with a read
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
      if (arst_n && ($countones(~ce_n) > 1 || (!oe_n && dq_oe))) begin
         $display("ERROR bus select expected one device seen %h", ce_n);
         n_fail++;
      end
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rchk("istat reset", FSR_OFF_ISTAT, 32'h0, 32'h7);
      rchk("rp level", FSR_OFF_CTRL, 32'h200, 32'h200);
      apb(1'b0, 8'h1c, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, FSR_OFF_ADDR, 32'h0);
      arm_dev(8'h03, 8'h00, 8'h40);
      run_op(FSR_OP_POLL_SR);
      rchk("dstat suspend", FSR_OFF_DSTAT, 32'hc0, 32'hff);
      rchk("istat pin", FSR_OFF_ISTAT, 32'h3, 32'h7);
      apb(1'b1, FSR_OFF_ISTAT, 32'h7);
      $display("test suspend done");
      apb(1'b1, FSR_OFF_IMASK, 32'h4);
      arm_dev(8'h01, 8'h00, 8'h38);
      run_op(FSR_OP_POLL_SR);
      rchk("dstat errors", FSR_OFF_DSTAT, 32'hb8, 32'hff);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, FSR_OFF_ISTAT, 32'h7);
      rchk("istat clear", FSR_OFF_ISTAT, 32'h0, 32'h7);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test errors done");
      arm_dev(8'h00, 8'h02, 8'h00);
      run_op(FSR_OP_POLL_XSR);
      rchk("xstat free", FSR_OFF_XSTAT, 32'h80, 32'hff);
      run_op(FSR_OP_READ_ID);
      rchk("id data", FSR_OFF_DATA, 32'h5a, 32'hff);
      $display("test buffer and id done");
      apb(1'b1, FSR_OFF_CTRL, {25'h0, FSR_OP_RESET, 4'h1});
      rchk("rp pulse", FSR_OFF_CTRL, 32'h0, 32'h200);
      wait_idle();
      rchk("rp back", FSR_OFF_CTRL, 32'h200, 32'h200);
      apb(1'b1, FSR_OFF_ADDR, 32'h12);
      run_op(FSR_OP_READ);
      rchk("array after reset", FSR_OFF_DATA, 32'h2e, 32'hff);
      $display("test power-down done");
      apb(1'b1, FSR_OFF_DATA, {24'h0, FSR_CMD_READ_ID});
      run_op(FSR_OP_WRITE);
      run_op(FSR_OP_READ);
      rchk("write op id", FSR_OFF_DATA, 32'h5a, 32'hff);
      @(posedge clk_sys);
      supply_ok <= 1'b0;
      rchk("rp supply low", FSR_OFF_CTRL, 32'h0, 32'h200);
      supply_ok <= 1'b1;
      rchk("rp supply back", FSR_OFF_CTRL, 32'h200, 32'h200);
      run_op(FSR_OP_READ);
      rchk("array after dip", FSR_OFF_DATA, 32'h2e, 32'hff);
      $display("test write and supply done");
      finish_test();
   end
endmodule // flash_status_reporting_test
`default_nettype wire
